// File: design/eecr_defines.vh
// Purpose: constants of the serial backup-RAM control-register unit
// Assumes: 100 MHz system clock
// Notes:   busy times have plain defaults; real values come from the part grade
`ifndef EECR_DEFINES_VH
`define EECR_DEFINES_VH

`define EECR_OPCODE          4'h3
`define EECR_ADDR_STATUS     8'h00
`define EECR_ADDR_TRIGGER    8'h55
`define EECR_CMD_STORE       8'h33
`define EECR_CMD_RECALL      8'hDD

`define EECR_BIT_MODIFIED    7
`define EECR_BP_HI           4
`define EECR_BP_LO           2
`define EECR_BIT_ASE         1
`define EECR_BIT_EVENT       0

`define EECR_RST_BP          3'h0
`define EECR_RST_ASE         1'h0
`define EECR_RST_EVENT       1'h0

`define EECR_CLK_NS          10
`define EECR_TWC_NS          1000000
`define EECR_STORE_NS        8000000
`define EECR_RECALL_NS       200000

`define EECR_ARRAY_WORDS     12'h800

`endif

// File: design/eecr_regs.v
// Purpose: control-register unit (status and store/recall trigger) on a two-wire bus
// Assumes: scl, sda, store pin and cap comparator are asynchronous pins
// Notes:   sram datapath lives outside; it reports writes and asks protection
//
// Summary of operation
// R01 - control unit selected only by control byte with opcode 0011.
// R02 - auto or pin store starting mid-transfer abandons the bus operation.
// R03 - two registers: status at 00h, write-only trigger at 55h.
// R04 - status: modified bit7, protect bits4-2, autostore bit1, event bit0.
// R05 - modified flag read-only, zero at reset, set by writes, cleared by store/recall.
// R06 - auto and pin stores need modified flag; software store always allowed.
// R07 - three-bit protect code selects upper 1/64 doubling to whole array.
// R08 - writes to protected addresses are refused by the sram datapath.
// R09 - autostore enable one stores on power-down if modified, else never.
// R10 - store pin high writes event flag after store; software may change it.
// R11 - store pin ignored while cap low or store/recall running.
// R12 - stop after status write starts write cycle; no response meanwhile.
// R13 - store triggered during status write waits; new autostore bit decides an autostore.
// R14 - code 33h starts store, no acknowledge meanwhile, clears modified flag.
// R15 - code DDh starts recall, no acknowledge meanwhile, clears modified flag.
// R16 - byte after control byte is register address, msb first, used once.
// R17 - unknown register address not acknowledged, bus ignored until start.
// R18 - host sends data byte after address, then a stop.
// R19 - any status value accepted; unknown command refused until next start.
// R20 - trigger write takes one data byte; a second is refused, operation aborted.
// R21 - status write may carry many bytes; last one before stop commits.
// R22 - host waits the busy time after the stop before next access.
// R23 - without backup cap the system should clear autostore enable.
// R24 - control read sends status, repeated while host acknowledges.
// R25 - busy durations are parameters; busy counter or low cap blocks the control-byte acknowledge.
`include "eecr_defines.vh"

module eecr_regs #(
  parameter integer TWC_CYC    = (`EECR_TWC_NS + `EECR_CLK_NS - 1) / `EECR_CLK_NS,
  parameter integer STORE_CYC  = (`EECR_STORE_NS + `EECR_CLK_NS - 1) / `EECR_CLK_NS,
  parameter integer RECALL_CYC = (`EECR_RECALL_NS + `EECR_CLK_NS - 1) / `EECR_CLK_NS
) (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe_out,
  input  wire        hw_store_pin_in,
  input  wire        cap_low_threshold_in,
  input  wire [1:0]  chip_sel_in,
  input  wire        sram_byte_written_in,
  input  wire [10:0] sram_addr_in,
  output wire        addr_protected_out,
  output wire [7:0]  config_flags_out,
  output wire        busy_out,
  output wire        store_active_out,
  output wire        recall_active_out
);
  localparam [2:0] ST_IDLE = 3'h0, ST_CTRL = 3'h1, ST_ADDR = 3'h2, ST_DATA = 3'h3;
  localparam [2:0] ST_ACK  = 3'h4, ST_READ = 3'h5, ST_RACK = 3'h6, ST_IGN  = 3'h7;
  localparam [2:0] K_NONE = 3'h0, K_SWR = 3'h1, K_STORE = 3'h2, K_RECALL = 3'h3;
  localparam [2:0] K_HSTORE = 3'h4, K_EVWR = 3'h5;

  wire scl_s;
  wire sda_s;
  wire hs_s;
  wire caplow_s;

  eecr_sync #(.INIT(1'b1)) u_scl (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
                                  .pin_in(scl_in), .level_out(scl_s));
  eecr_sync #(.INIT(1'b1)) u_sda (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
                                  .pin_in(sda_in), .level_out(sda_s));
  eecr_sync #(.INIT(1'b0)) u_hs  (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
                                  .pin_in(hw_store_pin_in), .level_out(hs_s));
  eecr_sync #(.INIT(1'b1)) u_cap (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
                                  .pin_in(cap_low_threshold_in), .level_out(caplow_s));

  reg        scl_q_r;
  reg        sda_q_r;
  reg        hs_q_r;
  reg        caplow_q_r;
  reg [2:0]  st_r;
  reg [2:0]  after_ack_r;
  reg [3:0]  cnt_r;
  reg [7:0]  sh_r;
  reg [7:0]  tx_r;
  reg        sel_trig_r;
  reg        got_data_r;
  reg        pend_stat_r;
  reg [7:0]  pend_val_r;
  reg [2:0]  pend_cmd_r;
  reg        array_modified_r;
  reg [2:0]  block_protect_r;
  reg        autostore_enable_r;
  reg        event_r;
  reg [2:0]  kind_r;
  reg [31:0] bcnt_r;
  reg        pend_hs_r;
  reg        pend_auto_r;
  reg        recalled_r;
  reg [2:0]  launch;

  // protected when code is nonzero and address lies in the top 2048>>(7-code) words
  function prot_hit;
    input [2:0]  code;
    input [10:0] addr;
    reg   [11:0] span;
    begin
      span = `EECR_ARRAY_WORDS >> (3'h7 - code);
      if (code == 3'h0) begin
        prot_hit = 1'b0;
      end else begin
        prot_hit = ({1'b0, addr} >= (`EECR_ARRAY_WORDS - span)); // R07
      end
    end
  endfunction

  function [31:0] busy_len;
    input [2:0] k;
    begin
      case (k)
        K_SWR, K_EVWR: busy_len = TWC_CYC;
        K_STORE, K_HSTORE: busy_len = STORE_CYC;
        K_RECALL: busy_len = RECALL_CYC;
        default: busy_len = 32'h0;
      endcase
    end
  endfunction

  wire [7:0] status_val = {array_modified_r, 2'b00, block_protect_r,
                           autostore_enable_r, event_r}; // R04
  wire scl_rise  = scl_s & ~scl_q_r;
  wire scl_fall  = ~scl_s & scl_q_r;
  wire bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  wire hs_edge   = hs_s & ~hs_q_r;
  wire cap_fall  = caplow_s & ~caplow_q_r;
  wire sr_busy   = (kind_r == K_STORE) | (kind_r == K_RECALL) | (kind_r == K_HSTORE);
  wire stat_busy = (kind_r == K_SWR) | (kind_r == K_EVWR);
  wire done      = (kind_r != K_NONE) && (bcnt_r == 32'h1);
  wire hs_ok     = hs_edge & ~caplow_s & ~sr_busy; // R11
  wire busy_any  = (kind_r != K_NONE) | caplow_s; // R25
  wire stop_cmt  = bus_stop & (pend_stat_r | (pend_cmd_r != K_NONE));
  wire ctrl_hit  = (sh_r[7:4] == `EECR_OPCODE) && (sh_r[3:2] == chip_sel_in)
                   && ~sh_r[1]; // R01

  assign sda_out            = 1'b0;
  assign addr_protected_out = prot_hit(block_protect_r, sram_addr_in); // R07 R08
  assign config_flags_out   = status_val;
  assign busy_out           = busy_any;
  assign store_active_out   = (kind_r == K_STORE) | (kind_r == K_HSTORE);
  assign recall_active_out  = (kind_r == K_RECALL);

  // one launch per cycle; power and pin events outrank a bus commit
  always @* begin
    launch = K_NONE;
    if (done && kind_r == K_HSTORE) begin
      launch = K_EVWR; // R10
    end else if (kind_r == K_NONE || done) begin
      if (kind_r == K_NONE && ~recalled_r && ~caplow_s) begin
        launch = K_RECALL;
      end else if ((cap_fall | (done & stat_busy & pend_auto_r))
                   & autostore_enable_r & array_modified_r) begin
        launch = K_STORE; // R06 R09 R13
      end else if (hs_ok | (done & stat_busy & pend_hs_r)) begin
        launch = array_modified_r ? K_HSTORE : K_EVWR; // R06 R10
      end else if (stop_cmt && kind_r == K_NONE) begin
        launch = pend_stat_r ? K_SWR : pend_cmd_r; // R12 R14 R15
      end
    end
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      scl_q_r            <= 1'b1;
      sda_q_r            <= 1'b1;
      hs_q_r             <= 1'b0;
      caplow_q_r         <= 1'b1;
      st_r               <= ST_IDLE;
      after_ack_r        <= ST_IDLE;
      cnt_r              <= 4'h0;
      sh_r               <= 8'h00;
      tx_r               <= 8'h00;
      sel_trig_r         <= 1'b0;
      got_data_r         <= 1'b0;
      pend_stat_r        <= 1'b0;
      pend_val_r         <= 8'h00;
      pend_cmd_r         <= K_NONE;
      sda_oe_out         <= 1'b0;
      array_modified_r   <= 1'b0; // R05
      block_protect_r    <= `EECR_RST_BP;
      autostore_enable_r <= `EECR_RST_ASE;
      event_r            <= `EECR_RST_EVENT;
      kind_r             <= K_NONE;
      bcnt_r             <= 32'h0;
      pend_hs_r          <= 1'b0;
      pend_auto_r        <= 1'b0;
      recalled_r         <= 1'b0;
    end else if (ce_in) begin
      scl_q_r    <= scl_s;
      sda_q_r    <= sda_s;
      hs_q_r     <= hs_s;
      caplow_q_r <= caplow_s;

      // busy sequencer
      if (stat_busy && !done) begin
        if (hs_ok) begin
          pend_hs_r <= 1'b1; // R13
        end
        if (cap_fall) begin
          pend_auto_r <= 1'b1; // R13
        end
      end
      if (done) begin
        pend_hs_r   <= 1'b0;
        pend_auto_r <= 1'b0;
        if (kind_r == K_EVWR) begin
          event_r <= 1'b1; // R10
        end
      end
      if (launch != K_NONE) begin
        kind_r <= launch;
        bcnt_r <= busy_len(launch); // R25
        if (launch == K_RECALL) begin
          recalled_r <= 1'b1;
        end
        if (launch == K_SWR) begin
          block_protect_r    <= pend_val_r[`EECR_BP_HI:`EECR_BP_LO]; // R21
          autostore_enable_r <= pend_val_r[`EECR_BIT_ASE];
          event_r            <= pend_val_r[`EECR_BIT_EVENT]; // R10
        end
      end else if (done) begin
        kind_r <= K_NONE;
        bcnt_r <= 32'h0;
      end else if (kind_r != K_NONE) begin
        bcnt_r <= bcnt_r - 32'h1;
      end

      // sram writes set the flag; a same-cycle completion loses
      if (sram_byte_written_in) begin
        array_modified_r <= 1'b1; // R05
      end else if (done && (kind_r == K_STORE || kind_r == K_RECALL
                            || kind_r == K_HSTORE)) begin
        array_modified_r <= 1'b0; // R05 R14 R15
      end

      // bus engine
      if (launch == K_STORE || launch == K_HSTORE || launch == K_EVWR) begin
        st_r        <= ST_IGN; // R02
        sda_oe_out  <= 1'b0;
        pend_stat_r <= 1'b0;
        pend_cmd_r  <= K_NONE;
      end else if (bus_start) begin
        st_r        <= ST_CTRL;
        cnt_r       <= 4'h0;
        sda_oe_out  <= 1'b0;
        pend_stat_r <= 1'b0;
        pend_cmd_r  <= K_NONE;
      end else if (bus_stop) begin
        st_r        <= ST_IDLE;
        sda_oe_out  <= 1'b0;
        pend_stat_r <= 1'b0;
        pend_cmd_r  <= K_NONE;
      end else begin
        case (st_r)
          ST_CTRL, ST_ADDR, ST_DATA: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s}; // R16
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              st_r  <= ST_IGN;
              if (st_r == ST_CTRL) begin
                if (ctrl_hit && !busy_any) begin
                  sda_oe_out  <= 1'b1;
                  st_r        <= ST_ACK;
                  after_ack_r <= sh_r[0] ? ST_READ : ST_ADDR; // R24
                end
              end else if (st_r == ST_ADDR) begin
                got_data_r <= 1'b0;
                sel_trig_r <= (sh_r == `EECR_ADDR_TRIGGER);
                if (sh_r == `EECR_ADDR_STATUS || sh_r == `EECR_ADDR_TRIGGER) begin
                  sda_oe_out  <= 1'b1; // R03 R17
                  st_r        <= ST_ACK;
                  after_ack_r <= ST_DATA;
                end
              end else if (!sel_trig_r) begin
                pend_stat_r <= 1'b1; // R19 R21
                pend_val_r  <= sh_r;
                sda_oe_out  <= 1'b1;
                st_r        <= ST_ACK;
                after_ack_r <= ST_DATA;
              end else if (!got_data_r && (sh_r == `EECR_CMD_STORE
                                           || sh_r == `EECR_CMD_RECALL)) begin
                got_data_r  <= 1'b1;
                pend_cmd_r  <= (sh_r == `EECR_CMD_STORE) ? K_STORE : K_RECALL; // R14 R15
                sda_oe_out  <= 1'b1;
                st_r        <= ST_ACK;
                after_ack_r <= ST_DATA;
              end else begin
                pend_cmd_r <= K_NONE; // R19 R20
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (after_ack_r == ST_READ) begin
                sda_oe_out <= ~status_val[7]; // R24
                tx_r       <= {status_val[6:0], 1'b0};
                cnt_r      <= 4'h1;
                st_r       <= ST_READ;
              end else begin
                sda_oe_out <= 1'b0;
                st_r       <= after_ack_r;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (cnt_r == 4'h8) begin
                sda_oe_out <= 1'b0;
                st_r       <= ST_RACK;
              end else begin
                sda_oe_out <= ~tx_r[7];
                tx_r       <= {tx_r[6:0], 1'b0};
                cnt_r      <= cnt_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              st_r        <= sda_s ? ST_IGN : ST_ACK; // R24
              after_ack_r <= ST_READ;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // eecr_regs

// File: design/eecr_sync.v
// Purpose: three-stage synchroniser for a pin from outside the clock domain
// Assumes: ce_in freezes all stages
// Notes:   output moves only when stages two and three agree
module eecr_sync #(
  parameter INIT = 1'b1
) (
  input  wire clock_in,
  input  wire rst_in,
  input  wire ce_in,
  input  wire pin_in,
  output reg  level_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clock_in) begin
    if (rst_in) begin
      s1_r      <= INIT;
      s2_r      <= INIT;
      s3_r      <= INIT;
      level_out <= INIT;
    end else if (ce_in) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule // eecr_sync

// File: sim/eecr_i2c_host.sv
// Purpose: two-wire bus host model facing the control-register unit
// Assumes: sda has a pull-up; one scl period is 16 system clocks (160 ns)
// Notes:   every pin change lands 1 ns after a clock edge; scl stands high between frames
module eecr_i2c_host (
  input  wire logic clock_in,
  input  wire logic sda_oe_in,
  input  wire logic sda_drv_in,
  output logic      scl_out,
  output wire logic sda_line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull_r = 1'h0;
  initial scl_out = 1'h1;
  // released line goes to the pull-up level
  assign sda_line_out = !(pull_r || (sda_oe_in && !sda_drv_in));
  task q;
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  task start;
    scl_out = 1'h1;
    q;
    pull_r = 1'h1;
    q;
    scl_out = 1'h0;
    q;
  endtask
  task stop;
    pull_r = 1'h1;
    q;
    scl_out = 1'h1;
    q;
    pull_r = 1'h0;
    q;
  endtask
  // data moves only while scl is low, sampled mid high phase
  task bitx(input logic b, output logic r);
    pull_r = !b;
    q;
    scl_out = 1'h1;
    q;
    r = sda_line_out;
    q;
    scl_out = 1'h0;
    q;
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'h1, r);
    ack = !r;
  endtask
  task rbyte(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'h1, v[i]);
    bitx(!more, r);
  endtask
endmodule // eecr_i2c_host

// File: sim/eecr_regs_properties.sv
// Purpose: port-level checks of the control-register unit
// Assumes: single clock domain, synchronous active-high reset
// Notes:   protect map recomputed from the visible protect field
module eecr_regs_properties #(
  parameter integer STORE_CYC = 40
) (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        sda_oe_out,
  input wire logic        cap_low_threshold_in,
  input wire logic        sram_byte_written_in,
  input wire logic [10:0] sram_addr_in,
  input wire logic        addr_protected_out,
  input wire logic [7:0]  config_flags_out,
  input wire logic        busy_out,
  input wire logic        store_active_out,
  input wire logic        recall_active_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [11:0] span;
  logic        prot_exp;
  integer      scnt_r;
  assign span = 12'h800 >> (3'h7 - config_flags_out[4:2]);
  assign prot_exp = (config_flags_out[4:2] != 3'h0) && ({1'h0, sram_addr_in} >= 12'h800 - span);
  always @(posedge clock_in) begin
    if (rst_in || !store_active_out) scnt_r <= 0;
    else scnt_r <= scnt_r + 1;
  end
  a_flags_reset: assert property (disable iff (1'h0) rst_in && ce_in |=> config_flags_out == 8'h00)
    else $error("flags not clear after reset");
  a_unused_zero: assert property (config_flags_out[6:5] == 2'h0)
    else $error("status bits 6:5 not zero");
  a_protect_map: assert property (addr_protected_out == prot_exp)
    else $error("protect decode wrong");
  a_mod_sets: assert property (sram_byte_written_in && !busy_out |-> ##[1:2] config_flags_out[7])
    else $error("modified flag not set by write");
  a_store_clear: assert property ($fell(store_active_out) |-> ##[0:1] !config_flags_out[7])
    else $error("modified flag kept after store");
  a_recall_clear: assert property ($fell(recall_active_out) |-> ##[0:1] !config_flags_out[7])
    else $error("modified flag kept after recall");
  a_store_length: assert property ($fell(store_active_out) |-> scnt_r == STORE_CYC)
    else $error("store time wrong");
  a_busy_no_ack: assert property (busy_out [*2] |-> !sda_oe_out)
    else $error("sda driven while busy");
  a_ack_idle: assert property ($rose(sda_oe_out) |-> !busy_out)
    else $error("drive started while busy");
  a_cap_busy: assert property (cap_low_threshold_in [*6] |-> busy_out)
    else $error("not busy with cap low");
  c_store: cover property ($rose(store_active_out));
  c_recall: cover property ($rose(recall_active_out));
  c_drive: cover property ($rose(sda_oe_out));
endmodule // eecr_regs_properties
bind eecr_regs eecr_regs_properties #(.STORE_CYC(STORE_CYC)) eecr_regs_properties_i (
  .clock_in, .rst_in, .ce_in, .sda_oe_out, .cap_low_threshold_in, .sram_byte_written_in,
  .sram_addr_in, .addr_protected_out, .config_flags_out, .busy_out, .store_active_out,
  .recall_active_out);

// File: sim/eecr_regs_test.sv
// Purpose: self-checking bench of the control-register unit over the two-wire bus
// Assumes: short busy times, chip select 01, clock enable held high
// Notes:   control byte 34h writes and 35h reads the registers
module eecr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in = 1'h0;
  logic        rst_in = 1'h1;
  logic        hw_store_pin_in = 1'h0;
  logic        cap_low_threshold_in = 1'h0;
  logic        sram_byte_written_in = 1'h0;
  logic [10:0] sram_addr_in = 11'h000;
  wire         scl, sda, sda_o, sda_oe_out, addr_protected_out, busy_out;
  wire         store_active_out, recall_active_out;
  wire  [7:0]  config_flags_out;
  logic [7:0]  rd, rd2, ac;
  int          errors = 0;
  int          n_compared = 0;
  always #5 clock_in = ~clock_in;
  eecr_regs #(.TWC_CYC(200), .STORE_CYC(400), .RECALL_CYC(300)) eecr_regs_i (
    .clock_in, .rst_in, .ce_in(1'h1), .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out,
    .hw_store_pin_in, .cap_low_threshold_in, .chip_sel_in(2'h1), .sram_byte_written_in,
    .sram_addr_in, .addr_protected_out, .config_flags_out, .busy_out, .store_active_out,
    .recall_active_out);
  eecr_i2c_host eecr_i2c_host_i (.clock_in, .sda_oe_in(sda_oe_out), .sda_drv_in(sda_o),
    .scl_out(scl), .sda_line_out(sda));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // bounded wait for the busy period to run out
  task idle;
    for (int i = 0; i < 3000 && busy_out !== 1'h0; i++) cyc(1);
    chk(busy_out, 1'h0);
  endtask
  // n bytes, first byte in the top slice; ack of byte i lands in bit i
  task wseq(input int n, input logic [31:0] b, output logic [7:0] acks);
    logic a;
    acks = 8'h00;
    eecr_i2c_host_i.start;
    for (int i = 0; i < n; i++) begin
      eecr_i2c_host_i.wbyte(b[31-8*i -: 8], a);
      acks[i] = a;
    end
    eecr_i2c_host_i.stop;
  endtask
  task rdst(output logic [7:0] v, output logic [7:0] v2);
    logic a;
    eecr_i2c_host_i.start;
    eecr_i2c_host_i.wbyte(8'h35, a);
    chk(a, 1'h1);
    eecr_i2c_host_i.rbyte(1'h1, v);
    eecr_i2c_host_i.rbyte(1'h0, v2);
    eecr_i2c_host_i.stop;
    chk(v2, v);
  endtask
  task pulse_write;
    sram_byte_written_in = 1'h1;
    cyc(1);
    sram_byte_written_in = 1'h0;
    cyc(3);
  endtask
  task pulse_pin;
    hw_store_pin_in = 1'h1;
    cyc(10);
    hw_store_pin_in = 1'h0;
    cyc(10);
  endtask
  initial begin
    #500000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    cyc(12);
    rst_in = 1'h0;
    cyc(10);
    idle;
    rdst(rd, rd2);
    chk(rd, 8'h00);
    $display("test power-up read done");
    wseq(4, 32'h3400FF0A, ac);
    chk(ac, 8'h0F);
    wseq(1, 32'h34000000, ac);
    chk(ac, 8'h00);
    idle;
    rdst(rd, rd2);
    chk(rd, 8'h0A);
    sram_addr_in = 11'h7C0;
    cyc(1);
    chk(addr_protected_out, 1'h1);
    sram_addr_in = 11'h7BF;
    cyc(1);
    chk(addr_protected_out, 1'h0);
    $display("test status write done");
    wseq(2, 32'hA4000000, ac);
    chk(ac, 8'h00);
    wseq(3, 32'h34011F00, ac);
    chk(ac, 8'h01);
    wseq(3, 32'h34553400, ac);
    chk(ac, 8'h03);
    wseq(4, 32'h34553333, ac);
    chk(ac, 8'h07);
    cyc(5);
    chk(store_active_out, 1'h0);
    rdst(rd, rd2);
    chk(rd, 8'h0A);
    $display("test refusals done");
    pulse_write;
    chk(config_flags_out, 8'h8A);
    wseq(3, 32'h34553300, ac);
    chk(ac, 8'h07);
    cyc(5);
    chk(store_active_out, 1'h1);
    idle;
    chk(config_flags_out, 8'h0A);
    pulse_write;
    wseq(3, 32'h3455DD00, ac);
    chk(ac, 8'h07);
    cyc(5);
    chk(recall_active_out, 1'h1);
    idle;
    chk(config_flags_out, 8'h0A);
    $display("test store and recall done");
    cap_low_threshold_in = 1'h1;
    cyc(10);
    pulse_pin;
    cap_low_threshold_in = 1'h0;
    cyc(10);
    idle;
    chk(config_flags_out, 8'h0A);
    pulse_pin;
    chk(store_active_out, 1'h0);
    idle;
    chk(config_flags_out, 8'h0B);
    pulse_write;
    cap_low_threshold_in = 1'h1;
    cyc(10);
    chk(store_active_out, 1'h1);
    cap_low_threshold_in = 1'h0;
    cyc(10);
    idle;
    chk(config_flags_out, 8'h0B);
    $display("test pin and autostore done");
    wseq(3, 32'h34000800, ac);
    chk(ac, 8'h07);
    idle;
    pulse_write;
    cap_low_threshold_in = 1'h1;
    cyc(10);
    chk(store_active_out, 1'h0);
    cap_low_threshold_in = 1'h0;
    cyc(10);
    idle;
    rdst(rd, rd2);
    chk(rd, 8'h88);
    pulse_pin;
    chk(store_active_out, 1'h1);
    idle;
    chk(config_flags_out, 8'h09);
    $display("test manual store done");
    wseq(3, 32'h34000800, ac);
    pulse_pin;
    idle;
    chk(config_flags_out, 8'h09);
    pulse_write;
    wseq(3, 32'h34000A00, ac);
    cap_low_threshold_in = 1'h1;
    cyc(10);
    cap_low_threshold_in = 1'h0;
    cyc(10);
    chk(store_active_out, 1'h0);
    cyc(200);
    chk(store_active_out, 1'h1);
    idle;
    chk(config_flags_out, 8'h0A);
    $display("test deferred store done");
    fork
      wseq(4, 32'h34000A0A, ac);
      begin
        cyc(200);
        pulse_pin;
      end
    join
    chk(ac, 8'h01);
    idle;
    chk(config_flags_out, 8'h0B);
    $display("test abort done");
    end_sim;
  end
endmodule // eecr_regs_test
